// *** cmpc_clock_control.sv ***
// Behaviour
// [RULE_01] Select bit one means master, zero slave.
// [RULE_02] Device comes out of reset as slave.
// [RULE_03] Master operation starts only on select write.
// [RULE_04] Frame and bit pins float while slave.
// [RULE_05] PLL power on makes internal clock from PLL; code uses master clock output, low while its enable is zero.
// [RULE_06] Lock within 160ms, 2ms or 10ms.
// [RULE_07] Reference code decode, other codes are invalid.
// [RULE_08] Rate codes with master clock reference.
// [RULE_09] Upper rate bits select range otherwise.
// [RULE_10] Master clocks low until first lock.
// [RULE_11] Regular clocks after one frame period.
// [RULE_12] Power off in master holds clocks low.
// [RULE_13] Locked frame at fs, bit per rate bit.
// [RULE_14] Output enable zero drives master clock low.
// [RULE_15] Slave mode master clock invalid until lock.
// [RULE_16] Converter data untrusted until lock.
// [RULE_17] Host mutes DAC paths during unlock.
// [RULE_18] Divider selects 256, 128, 64, 32fs.
// [RULE_19] Bit clock rate selects 32fs or 64fs.
// [RULE_20] Power off bypasses PLL with clock input.
// [RULE_21] Lock modelled by counter from restart.
`timescale 1ns/100ps
`default_nettype none
`include "cmpc_map.svh"

module cmpc_clock_control #(
    parameter logic [`CMPC_LOCK_W-1:0] LOCK_FRAME_CYC =
        `CMPC_LOCK_W'(`CMPC_LOCK_FRAME_MS * (`CMPC_CLK_HZ / 1000)),
    parameter logic [`CMPC_LOCK_W-1:0] LOCK_BIT_CYC =
        `CMPC_LOCK_W'(`CMPC_LOCK_BIT_MS * (`CMPC_CLK_HZ / 1000)),
    parameter logic [`CMPC_LOCK_W-1:0] LOCK_MCLK_CYC =
        `CMPC_LOCK_W'(`CMPC_LOCK_MCLK_MS * (`CMPC_CLK_HZ / 1000))
) (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       ms_select,
    input  wire logic       pll_power,
    input  wire logic [3:0] pll_ref_select,
    input  wire logic [3:0] rate_select,
    input  wire logic       mclk_out_enable,
    input  wire logic [1:0] mclk_out_divider,
    input  wire logic       bit_clock_rate,
    input  wire logic       master_clock_in,
    input  wire logic       frame_clock_in,
    input  wire logic       bit_clock_in,
    output logic            frame_clock_out,
    output logic            frame_clock_oe,
    output logic            bit_clock_out,
    output logic            bit_clock_oe,
    output logic            master_clock_out,
    output logic            internal_clock,
    output logic            pll_clock_selected,
    output logic            pll_locked,
    output logic            config_invalid,
    output logic            converter_data_valid
);

    // ------------------------------------------------------------------------
    // Decoding of reference and rate
    // ------------------------------------------------------------------------

    // Half period, in cycles, of a 32fs bit clock at the given rate.
    function automatic logic [7:0] half_for_fs(input logic [3:0] code, input logic ref_mclk);
        logic [31:0] h;
        h = 32'h0;
        if (ref_mclk) begin
            case (code) // RULE_08
                4'h0: h = `CMPC_CLK_HZ / (`CMPC_HALF_32FS * `CMPC_FS_8K);
                4'h1: h = `CMPC_CLK_HZ / (`CMPC_HALF_32FS * `CMPC_FS_12K);
                4'h2: h = `CMPC_CLK_HZ / (`CMPC_HALF_32FS * `CMPC_FS_16K);
                4'h3: h = `CMPC_CLK_HZ / (`CMPC_HALF_32FS * `CMPC_FS_24K);
                4'h4: h = `CMPC_CLK_HZ / (`CMPC_HALF_32FS * `CMPC_FS_7K35);
                4'h5: h = `CMPC_CLK_HZ / (`CMPC_HALF_32FS * `CMPC_FS_11K025);
                4'h6: h = `CMPC_CLK_HZ / (`CMPC_HALF_32FS * `CMPC_FS_14K7);
                4'h7: h = `CMPC_CLK_HZ / (`CMPC_HALF_32FS * `CMPC_FS_22K05);
                4'ha: h = `CMPC_CLK_HZ / (`CMPC_HALF_32FS * `CMPC_FS_32K);
                4'hb: h = `CMPC_CLK_HZ / (`CMPC_HALF_32FS * `CMPC_FS_48K);
                4'he: h = `CMPC_CLK_HZ / (`CMPC_HALF_32FS * `CMPC_FS_29K4);
                4'hf: h = `CMPC_CLK_HZ / (`CMPC_HALF_32FS * `CMPC_FS_44K1);
                default: h = 32'h0;
            endcase
        end else begin
            case (code[3:2]) // RULE_09
                2'h0: h = `CMPC_CLK_HZ / (`CMPC_HALF_32FS * `CMPC_FS_12K);
                2'h1: h = `CMPC_CLK_HZ / (`CMPC_HALF_32FS * `CMPC_FS_24K);
                2'h2: h = `CMPC_CLK_HZ / (`CMPC_HALF_32FS * `CMPC_FS_48K);
                default: h = 32'h0;
            endcase
        end
        half_for_fs = h[7:0];
    endfunction : half_for_fs

    cmpc_pkg::cmpc_state_type s_q;
    cmpc_pkg::cmpc_state_type s_d;

    logic                    ref_is_master_clk_flag;
    logic                    ref_valid;
    logic                    rate_valid;
    logic [`CMPC_LOCK_W-1:0] lock_limit;
    logic [7:0]              base_half;
    logic [7:0]              bit_half;
    logic [7:0]              mck_half;
    logic [5:0]              bit_last;
    logic                    restart;
    logic                    timer_run;
    logic                    timer_locked;

    assign ref_is_master_clk_flag = pll_ref_select[`CMPC_REF_MCLK_BIT];

    always_comb begin
        ref_valid  = 1'b1;
        lock_limit = LOCK_MCLK_CYC;
        if (pll_ref_select == `CMPC_REF_FRAME_1FS) begin // RULE_07
            lock_limit = LOCK_FRAME_CYC; // RULE_06
        end else if (pll_ref_select == `CMPC_REF_BIT_32FS || pll_ref_select == `CMPC_REF_BIT_64FS) begin
            lock_limit = LOCK_BIT_CYC; // RULE_06
        end else if (pll_ref_select == `CMPC_REF_MCLK_11M2896 || pll_ref_select == `CMPC_REF_MCLK_12M ||
                     pll_ref_select == `CMPC_REF_MCLK_24M || pll_ref_select == `CMPC_REF_MCLK_13M5 ||
                     pll_ref_select == `CMPC_REF_MCLK_27M) begin
            lock_limit = LOCK_MCLK_CYC; // RULE_06
        end else begin
            ref_valid = 1'b0; // RULE_07
        end
    end

    always_comb begin
        base_half  = half_for_fs(rate_select, ref_is_master_clk_flag);
        rate_valid = (base_half != 8'h0);
        bit_half   = bit_clock_rate ? (base_half >> 1) : base_half; // RULE_19
        bit_last   = bit_clock_rate ? `CMPC_BITS_64FS : `CMPC_BITS_32FS;
        case (mclk_out_divider) // RULE_18
            2'h0:    mck_half = base_half >> 3;
            2'h1:    mck_half = base_half >> 2;
            2'h2:    mck_half = base_half >> 1;
            default: mck_half = base_half;
        endcase
        if (bit_half == 8'h0) begin
            bit_half = 8'h1;
        end
        if (mck_half == 8'h0) begin
            mck_half = 8'h1;
        end
    end

    // ------------------------------------------------------------------------
    // Lock timer
    // ------------------------------------------------------------------------

    assign restart   = (pll_power && !s_q.power_prev) ||
                       (pll_power && (rate_select != s_q.rate_prev || pll_ref_select != s_q.ref_prev)); // RULE_06
    assign timer_run = pll_power && ref_valid && rate_valid;

    cmpc_lock_timer u_lock_timer (
        .clk     (clk),
        .arst_n  (arst_n),
        .restart (restart),
        .run     (timer_run),
        .limit   (lock_limit),
        .locked  (timer_locked)
    );

    // ------------------------------------------------------------------------
    // State update
    // ------------------------------------------------------------------------

    always_comb begin
        s_d            = s_q;
        s_d.master     = ms_select; // RULE_01 RULE_03
        s_d.power_prev = pll_power;
        s_d.rate_prev  = rate_select;
        s_d.ref_prev   = pll_ref_select;
        s_d.mci_meta   = master_clock_in;
        s_d.mci_sync   = s_q.mci_meta;

        case (s_q.pll)
            cmpc_pkg::CMPC_PLL_OFF: begin
                if (pll_power) begin
                    s_d.pll = cmpc_pkg::CMPC_PLL_FIRST;
                end
            end
            cmpc_pkg::CMPC_PLL_FIRST, cmpc_pkg::CMPC_PLL_RELCK: begin
                if (!pll_power) begin
                    s_d.pll = cmpc_pkg::CMPC_PLL_OFF;
                end else if (timer_locked && !restart) begin
                    s_d.pll = cmpc_pkg::CMPC_PLL_SETTL;
                end
            end
            cmpc_pkg::CMPC_PLL_SETTL, cmpc_pkg::CMPC_PLL_LOCK: begin
                if (!pll_power) begin
                    s_d.pll = cmpc_pkg::CMPC_PLL_OFF;
                end else if (restart || !timer_locked) begin
                    s_d.pll = cmpc_pkg::CMPC_PLL_RELCK;
                end else if (s_q.pll == cmpc_pkg::CMPC_PLL_SETTL && s_q.bit_phase == bit_last &&
                             s_q.bit_lvl && s_q.bit_cnt == 8'h0) begin
                    s_d.pll = cmpc_pkg::CMPC_PLL_LOCK; // RULE_11
                end
            end
            default: begin
                s_d.pll = cmpc_pkg::CMPC_PLL_OFF;
            end
        endcase

        // Bit and frame clock dividers run only once the loop has locked.
        if (s_q.pll == cmpc_pkg::CMPC_PLL_OFF || s_q.pll == cmpc_pkg::CMPC_PLL_FIRST) begin
            s_d.bit_cnt   = '0; // RULE_10 RULE_12
            s_d.bit_lvl   = 1'b0;
            s_d.bit_phase = '0;
            s_d.frame_lvl = 1'b0;
        end else if (s_q.bit_cnt >= bit_half - 8'h1) begin
            s_d.bit_cnt = '0;
            s_d.bit_lvl = !s_q.bit_lvl;
            if (s_q.bit_lvl) begin
                s_d.bit_phase = (s_q.bit_phase >= bit_last) ? 6'h0 : s_q.bit_phase + 6'h1;
                s_d.frame_lvl = (s_d.bit_phase > (bit_last >> 1)); // RULE_13
            end
        end else begin
            s_d.bit_cnt = s_q.bit_cnt + 8'h1;
        end

        // Master clock output: toggles every cycle until lock, divider after.
        if (!mclk_out_enable || s_q.pll == cmpc_pkg::CMPC_PLL_OFF) begin
            s_d.mck_cnt = '0; // RULE_14
            s_d.mck_lvl = 1'b0;
        end else if (s_q.pll == cmpc_pkg::CMPC_PLL_FIRST || s_q.pll == cmpc_pkg::CMPC_PLL_RELCK) begin
            s_d.mck_cnt = '0; // RULE_10 RULE_15
            s_d.mck_lvl = !s_q.mck_lvl;
        end else if (s_q.mck_cnt >= mck_half - 8'h1) begin
            s_d.mck_cnt = '0; // RULE_15 RULE_18
            s_d.mck_lvl = !s_q.mck_lvl;
        end else begin
            s_d.mck_cnt = s_q.mck_cnt + 8'h1;
        end

        // Internal clock: PLL divider when powered, clock input otherwise.
        s_d.int_clk = pll_power ? s_q.mck_lvl : s_q.mci_sync; // RULE_05 RULE_20
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q        <= '0;
            s_q.master <= `CMPC_MS_RESET; // RULE_02
            s_q.pll    <= cmpc_pkg::CMPC_PLL_OFF;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------

    assign frame_clock_oe       = s_q.master; // RULE_04
    assign bit_clock_oe         = s_q.master; // RULE_04
    assign frame_clock_out      = s_q.frame_lvl;
    assign bit_clock_out        = s_q.bit_lvl;
    assign master_clock_out     = s_q.mck_lvl;
    assign internal_clock       = s_q.int_clk;
    assign pll_clock_selected   = s_q.power_prev;
    assign pll_locked           = s_q.pll == cmpc_pkg::CMPC_PLL_SETTL || s_q.pll == cmpc_pkg::CMPC_PLL_LOCK;
    assign config_invalid       = pll_power && !(ref_valid && rate_valid);
    assign converter_data_valid = !s_q.power_prev || s_q.pll == cmpc_pkg::CMPC_PLL_LOCK; // RULE_16 RULE_17

    // Slave-side pin inputs are carried for the far end; they do not steer this block.
    logic unused_inputs;
    assign unused_inputs = frame_clock_in ^ bit_clock_in;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------

    sequence power_rise_s;
        !pll_power ##1 pll_power;
    endsequence

    sequence first_wait_s;
        s_q.pll == cmpc_pkg::CMPC_PLL_FIRST [*2];
    endsequence

    chk_reset_slave: assert property (@(posedge clk) $rose(arst_n) |-> !frame_clock_oe && !bit_clock_oe) // RULE_02
        else $error("pins driven right after reset");

    chk_master_follow: assert property (@(posedge clk) disable iff (!arst_n)
        ms_select |=> frame_clock_oe && bit_clock_oe) // RULE_01 RULE_03
        else $error("master select not followed");

    chk_slave_float: assert property (@(posedge clk) disable iff (!arst_n)
        !ms_select |=> !frame_clock_oe && !bit_clock_oe) // RULE_04
        else $error("pins driven in slave mode");

    chk_first_low: assert property (@(posedge clk) disable iff (!arst_n)
        power_rise_s ##1 first_wait_s |-> !frame_clock_out && !bit_clock_out) // RULE_10
        else $error("clocks not low before first lock");

    chk_mclk_low: assert property (@(posedge clk) disable iff (!arst_n)
        !mclk_out_enable |=> !master_clock_out) // RULE_14
        else $error("master clock out not low when disabled");

    chk_off_low: assert property (@(posedge clk) disable iff (!arst_n)
        !pll_power ##1 !pll_power |=> !frame_clock_out && !bit_clock_out) // RULE_12
        else $error("clocks not held low with loop off");

    chk_no_early_lock: assert property (@(posedge clk) disable iff (!arst_n)
        power_rise_s |-> !pll_locked ##1 !pll_locked) // RULE_06 RULE_21
        else $error("lock reported at restart");

    chk_bypass_sel: assert property (@(posedge clk) disable iff (!arst_n)
        !pll_power |=> !pll_clock_selected) // RULE_20
        else $error("loop clock selected while off");

    chk_invalid_nolock: assert property (@(posedge clk) disable iff (!arst_n)
        config_invalid [*3] |-> !pll_locked) // RULE_07
        else $error("lock with invalid setting");

    chk_data_untrusted: assert property (@(posedge clk) disable iff (!arst_n)
        pll_power && pll_clock_selected && !pll_locked |-> !converter_data_valid) // RULE_16
        else $error("data valid while unlocked");

endmodule : cmpc_clock_control

`default_nettype wire

// *** cmpc_clock_control_test.sv ***
`timescale 1ns/100ps
`default_nettype none

module cmpc_clock_control_test;
    logic       clk              = 1'b0;
    logic       arst_n           = 1'b0;
    logic       ms_select        = 1'b0;
    logic       pll_power        = 1'b0;
    logic [3:0] pll_ref_select   = 4'h6;
    logic [3:0] rate_select      = 4'h0;
    logic       mclk_out_enable  = 1'b0;
    logic [1:0] mclk_out_divider = 2'h0;
    logic       bit_clock_rate   = 1'b0;
    wire logic  master_clock_in;
    wire logic  frame_clock_in;
    wire logic  bit_clock_in;
    logic       frame_clock_out, frame_clock_oe, bit_clock_out, bit_clock_oe;
    logic       master_clock_out, internal_clock, pll_clock_selected;
    logic       pll_locked, config_invalid, converter_data_valid, dac_on;
    int         errors     = 0;
    int         n_compared = 0;

    always #50 clk = ~clk;

    cmpc_clock_control #(
        .LOCK_FRAME_CYC (21'h28),
        .LOCK_BIT_CYC   (21'h0a),
        .LOCK_MCLK_CYC  (21'h14)
    ) dut (
        .clk(clk), .arst_n(arst_n), .ms_select(ms_select), .pll_power(pll_power),
        .pll_ref_select(pll_ref_select), .rate_select(rate_select),
        .mclk_out_enable(mclk_out_enable), .mclk_out_divider(mclk_out_divider),
        .bit_clock_rate(bit_clock_rate), .master_clock_in(master_clock_in),
        .frame_clock_in(frame_clock_in), .bit_clock_in(bit_clock_in),
        .frame_clock_out(frame_clock_out), .frame_clock_oe(frame_clock_oe),
        .bit_clock_out(bit_clock_out), .bit_clock_oe(bit_clock_oe),
        .master_clock_out(master_clock_out), .internal_clock(internal_clock),
        .pll_clock_selected(pll_clock_selected), .pll_locked(pll_locked),
        .config_invalid(config_invalid), .converter_data_valid(converter_data_valid)
    );

    cmpc_host_model host (
        .clk(clk), .arst_n(arst_n), .frame_clock_out(frame_clock_out),
        .frame_clock_oe(frame_clock_oe), .bit_clock_out(bit_clock_out),
        .bit_clock_oe(bit_clock_oe), .converter_data_valid(converter_data_valid),
        .master_clock_in(master_clock_in), .frame_clock_in(frame_clock_in),
        .bit_clock_in(bit_clock_in), .dac_paths_enable(dac_on)
    );

    // ------------------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    function automatic logic pick(input int sel);
        return (sel == 0) ? master_clock_out : (sel == 1) ? internal_clock : bit_clock_out;
    endfunction : pick

    // Counts rising edges of the chosen output over a number of cycles.
    task automatic rises(input int sel, input int cycles, output int n);
        logic prev;
        n    = 0;
        prev = pick(sel);
        repeat (cycles) begin
            step(1);
            if (pick(sel) === 1'b1 && prev === 1'b0) n++;
            prev = pick(sel);
        end
    endtask : rises

    task automatic report_and_stop;
        if (errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_mode;
        check("frame_oe_reset", frame_clock_oe, 32'h0);
        check("bit_oe_reset", bit_clock_oe, 32'h0);
        step(3);
        check("oe_before_write", frame_clock_oe, 32'h0);
        ms_select = 1'b1;
        step(1);
        check("frame_oe_master", frame_clock_oe, 32'h1);
        check("bit_oe_master", bit_clock_oe, 32'h1);
        ms_select = 1'b0;
        step(1);
        check("bit_oe_slave", bit_clock_oe, 32'h0);
    endtask : t_mode

    task automatic t_lock(input logic [3:0] ref_code, input int lim, input logic ms, input logic mck);
        int   n;
        int   mt;
        logic low;
        pll_power       = 1'b0;
        ms_select       = ms;
        mclk_out_enable = mck;
        step(3);
        pll_ref_select = ref_code;
        rate_select    = 4'h0;
        pll_power      = 1'b1;
        n   = 0;
        mt  = 0;
        low = 1'b1;
        while (pll_locked !== 1'b1 && n < 300) begin
            step(1);
            n++;
            if (ms && (frame_clock_out !== 1'b0 || bit_clock_out !== 1'b0)) low = 1'b0;
            if (!mck && master_clock_out !== 1'b0) low = 1'b0;
            if (master_clock_out === 1'b1) mt++;
        end
        check("lock_in_time", 32'(n >= lim && n <= lim + 6), 32'h1);
        check("held_low", low, 32'h1);
        check("pll_selected", pll_clock_selected, 32'h1);
        check("data_untrusted", converter_data_valid, 32'h0);
        check("dac_muted", dac_on, 32'h0);
        if (mck) check("mclk_invalid_runs", 32'(mt > 0), 32'h1);
    endtask : t_lock

    task automatic t_codes;
        logic [15:0] ref_ok  = 16'h30dd;
        logic [15:0] mck_ok  = 16'hccff;
        logic [15:0] pin_ok  = 16'h0fff;
        pll_power = 1'b1;
        for (int i = 0; i < 16; i++) begin
            pll_ref_select = i[3:0];
            rate_select    = 4'h0;
            step(1);
            check("ref_code", config_invalid, 32'(!ref_ok[i]));
            pll_ref_select = 4'h6;
            rate_select    = i[3:0];
            step(1);
            check("rate_mclk", config_invalid, 32'(!mck_ok[i]));
            pll_ref_select = 4'h0;
            step(1);
            check("rate_pin", config_invalid, 32'(!pin_ok[i]));
        end
        step(1);
    endtask : t_codes

    task automatic t_frame;
        int n;
        int b;
        logic pf;
        n = 0;
        while (converter_data_valid !== 1'b1 && n < 3000) begin
            step(1);
            n++;
        end
        check("regular_after_frame", converter_data_valid, 32'h1);
        for (int r = 0; r < 2; r++) begin
            bit_clock_rate = r[0];
            for (int f = 0; f < 3; f++) begin
                b  = 0;
                n  = 0;
                pf = frame_clock_out;
                while (!(frame_clock_out === 1'b1 && pf === 1'b0) && n < 6000) begin
                    pf = frame_clock_out;
                    step(1);
                    n++;
                end
                if (f < 2) continue;
                rises(2, 0, b);
            end
            pf = frame_clock_out;
            b  = 0;
            n  = 0;
            begin : count_bits
                logic pb;
                pb = bit_clock_out;
                while (n < 6000) begin
                    step(1);
                    n++;
                    if (bit_clock_out === 1'b1 && pb === 1'b0) b++;
                    pb = bit_clock_out;
                    if (frame_clock_out === 1'b1 && pf === 1'b0) break;
                    pf = frame_clock_out;
                end
            end
            check("bits_per_frame", b, r ? 32'h40 : 32'h20);
        end
    endtask : t_frame

    task automatic t_divider;
        int fast;
        int slow;
        mclk_out_divider = 2'h0;
        step(8);
        rises(0, 512, fast);
        mclk_out_divider = 2'h3;
        step(64);
        rises(0, 512, slow);
        check("div_ratio", 32'(fast > slow * 4), 32'h1);
    endtask : t_divider

    task automatic t_off;
        int n;
        pll_power = 1'b0;
        step(2);
        check("frame_low_off", frame_clock_out, 32'h0);
        check("bit_low_off", bit_clock_out, 32'h0);
        check("pll_deselected", pll_clock_selected, 32'h0);
        rises(1, 40, n);
        check("bypass_clock", 32'(n >= 8), 32'h1);
        mclk_out_enable = 1'b0;
        rises(0, 40, n);
        check("mclk_low_disabled", n, 32'h0);
    endtask : t_off

    initial begin
        #3000000;
        errors++;
        report_and_stop();
    end

    initial begin
        repeat (10) @(posedge clk);
        #1 arst_n = 1'b1;
        t_mode();
        t_codes();
        t_lock(4'h6, 20, 1'b1, 1'b0);
        t_lock(4'h0, 40, 1'b0, 1'b1);
        t_divider();
        t_lock(4'h3, 10, 1'b1, 1'b0);
        t_frame();
        t_off();
        report_and_stop();
    end
endmodule : cmpc_clock_control_test

`default_nettype wire

// *** cmpc_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none

module cmpc_host_model (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic frame_clock_out,
    input  wire logic frame_clock_oe,
    input  wire logic bit_clock_out,
    input  wire logic bit_clock_oe,
    input  wire logic converter_data_valid,
    output logic      master_clock_in,
    output logic      frame_clock_in,
    output logic      bit_clock_in,
    output logic      dac_paths_enable
);
    logic [7:0] div_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    // The host drives the serial clocks only while the device does not.
    assign master_clock_in  = div_q[1];
    assign bit_clock_in     = bit_clock_oe ? bit_clock_out : div_q[1];
    assign frame_clock_in   = frame_clock_oe ? frame_clock_out : div_q[7];
    assign dac_paths_enable = converter_data_valid;
endmodule : cmpc_host_model

`default_nettype wire

// *** cmpc_lock_timer.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "cmpc_map.svh"

module cmpc_lock_timer (
    input  wire logic                   clk,
    input  wire logic                   arst_n,
    input  wire logic                   restart,
    input  wire logic                   run,
    input  wire logic [`CMPC_LOCK_W-1:0] limit,
    output logic                        locked
);

    cmpc_pkg::cmpc_timer_state_type s_q;
    cmpc_pkg::cmpc_timer_state_type s_d;

    // Counts whole cycles from a restart and reports lock once the limit is met.
    always_comb begin
        s_d = s_q;
        if (restart || !run) begin
            s_d.count  = '0;
            s_d.locked = 1'b0;
        end else if (s_q.count >= limit) begin
            s_d.locked = 1'b1; // RULE_21
        end else begin
            s_d.count = s_q.count + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign locked = s_q.locked;

endmodule : cmpc_lock_timer

`default_nettype wire

// *** cmpc_map.svh ***
`ifndef CMPC_MAP_SVH
`define CMPC_MAP_SVH

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define CMPC_CLK_HZ           10000000
`define CMPC_LOCK_FRAME_MS    160
`define CMPC_LOCK_BIT_MS      2
`define CMPC_LOCK_MCLK_MS     10
`define CMPC_LOCK_W           21

// ----------------------------------------------------------------------------
// PLL reference codes
// ----------------------------------------------------------------------------
`define CMPC_REF_FRAME_1FS    4'h0
`define CMPC_REF_BIT_32FS     4'h2
`define CMPC_REF_BIT_64FS     4'h3
`define CMPC_REF_MCLK_11M2896 4'h4
`define CMPC_REF_MCLK_12M     4'h6
`define CMPC_REF_MCLK_24M     4'h7
`define CMPC_REF_MCLK_13M5    4'hc
`define CMPC_REF_MCLK_27M     4'hd
`define CMPC_REF_MCLK_BIT     2

// ----------------------------------------------------------------------------
// Sampling rates in Hz
// ----------------------------------------------------------------------------
`define CMPC_FS_7K35          7350
`define CMPC_FS_8K            8000
`define CMPC_FS_11K025        11025
`define CMPC_FS_12K           12000
`define CMPC_FS_14K7          14700
`define CMPC_FS_16K           16000
`define CMPC_FS_22K05         22050
`define CMPC_FS_24K           24000
`define CMPC_FS_29K4          29400
`define CMPC_FS_32K           32000
`define CMPC_FS_44K1          44100
`define CMPC_FS_48K           48000

// ----------------------------------------------------------------------------
// Reset values and clock ratios
// ----------------------------------------------------------------------------
`define CMPC_MS_RESET         1'b0
`define CMPC_BITS_32FS        6'h1f
`define CMPC_BITS_64FS        6'h3f
`define CMPC_HALF_32FS        64

`endif

// *** cmpc_pkg.sv ***
`default_nettype none

package cmpc_pkg;

    typedef enum logic [2:0] {
        CMPC_PLL_OFF   = 3'b000,
        CMPC_PLL_FIRST = 3'b001,
        CMPC_PLL_RELCK = 3'b010,
        CMPC_PLL_SETTL = 3'b011,
        CMPC_PLL_LOCK  = 3'b100
    } cmpc_pll_state_type;

    typedef struct packed {
        logic [20:0] count;
        logic        locked;
    } cmpc_timer_state_type;

    typedef struct packed {
        logic               master;
        cmpc_pll_state_type pll;
        logic               power_prev;
        logic [3:0]         rate_prev;
        logic [3:0]         ref_prev;
        logic [7:0]         bit_cnt;
        logic               bit_lvl;
        logic [5:0]         bit_phase;
        logic               frame_lvl;
        logic [7:0]         mck_cnt;
        logic               mck_lvl;
        logic               mci_meta;
        logic               mci_sync;
        logic               int_clk;
    } cmpc_state_type;

endpackage : cmpc_pkg

`default_nettype wire
